/* File: hdl/spimsp_regs.vh */
// register map, field positions and transfer length of the serial port
`ifndef SPIMSP_REGS_VH
`define SPIMSP_REGS_VH
// byte addresses of the three registers
`define SPIMSP_DATA_ADDR 12'h000
`define SPIMSP_CTRL_ADDR 12'h004
`define SPIMSP_STAT_ADDR 12'h008
// control register fields
`define SPIMSP_CTRL_IRQ_EN 7
`define SPIMSP_CTRL_PORT_EN 6
`define SPIMSP_CTRL_RATE2 5
`define SPIMSP_CTRL_MASTER 4
`define SPIMSP_CTRL_IDLE 3
`define SPIMSP_CTRL_PHASE 2
`define SPIMSP_CTRL_RATE1 1
`define SPIMSP_CTRL_RATE0 0
`define SPIMSP_CTRL_RESET 8'h00
// status register fields
`define SPIMSP_STAT_DONE 7
`define SPIMSP_STAT_WRITE_COLLISION_FLAG 6
`define SPIMSP_STAT_OVR 5
`define SPIMSP_STAT_MODE_FAULT_FLAG 4
`define SPIMSP_STAT_ODIS 2
`define SPIMSP_STAT_SSM 1
`define SPIMSP_STAT_SSI 0
`define SPIMSP_STAT_RESET 8'h00
// bits per transfer
`define SPIMSP_BITS 4'd8
`endif

/* File: hdl/spimsp_port.v */
// spi master/slave port with apb register access
`timescale 1ns/1ps
`include "spimsp_regs.vh"

module spimsp_port
(
  // apb clock and reset
  input wire pclk,
  input wire presetn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // interrupt / halt wake request
  output reg irq,
  // serial clock pin
  input wire sck_in,
  output reg sck_out,
  output reg sck_oe,
  // master-out slave-in pin
  input wire mosi_in,
  output reg mosi_out,
  output reg mosi_oe,
  // master-in slave-out pin
  input wire miso_in,
  output reg miso_out,
  output reg miso_oe,
  // slave select pin, active low
  input wire ss_n_in,
  // high while the port owns the pins
  output reg pins_owned
);

  // half period in pclk cycles for the rate code
  function [6:0] half_period;
    input [2:0] code;
    begin
      case (code)
        3'b100: half_period = 7'd2;
        3'b000: half_period = 7'd4;
        3'b001: half_period = 7'd8;
        3'b110: half_period = 7'd16;
        3'b010: half_period = 7'd32;
        3'b011: half_period = 7'd64;
        default: half_period = 7'd64;
      endcase
    end
  endfunction

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  reg [1:0] sck_s_q, mosi_s_q, miso_s_q, ss_s_q;
  reg sck_prev_q;
  // two flops before anything looks at a pin
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sck_s_q <= 2'b00;
      mosi_s_q <= 2'b00;
      miso_s_q <= 2'b00;
      ss_s_q <= 2'b11;
      sck_prev_q <= 1'b0;
    end
    else
    begin
      sck_s_q <= {sck_s_q[0], sck_in};
      mosi_s_q <= {mosi_s_q[0], mosi_in};
      miso_s_q <= {miso_s_q[0], miso_in};
      ss_s_q <= {ss_s_q[0], ss_n_in};
      sck_prev_q <= sck_s_q[1];
    end
  end

  // ************************************************************
  // registers and state
  // ************************************************************
  reg [7:0] ctrl_q;
  reg done_q, write_collision_flag_q, ovr_q, mode_fault_flag_q;
  reg odis_q, ssm_q, ssi_q;
  reg [7:0] shift_q, rxbuf_q;
  reg [3:0] bitcnt_q;
  reg busy_q;
  reg sclk_q;
  reg [6:0] div_q;
  reg phase_half_q;
  reg done_seen_q; // status accessed while done set
  reg mode_fault_flag_seen_q; // status read while fault set
  reg write_collision_flag_seen_q; // status accessed while collision set
  reg latched_q; // buffer held since last done clear
  reg in_bit_q; // sampled bit awaiting shift

  wire master = ctrl_q[`SPIMSP_CTRL_MASTER];
  wire enable = ctrl_q[`SPIMSP_CTRL_PORT_EN];
  wire clock_idle_level = ctrl_q[`SPIMSP_CTRL_IDLE];
  wire capture_edge_sel = ctrl_q[`SPIMSP_CTRL_PHASE];
  wire [2:0] rate = {ctrl_q[`SPIMSP_CTRL_RATE2], ctrl_q[`SPIMSP_CTRL_RATE1],
    ctrl_q[`SPIMSP_CTRL_RATE0]};
  // effective select: soft bit or pin
  wire sel_n = ssm_q ? ssi_q : ss_s_q[1];

  // apb decode
  // taken once: the ready cycle must not repeat a write or a clear
  wire acc = psel & penable & ~pready;
  wire wr = acc & pwrite;
  wire rd = acc & ~pwrite;
  wire hit_data = (paddr == `SPIMSP_DATA_ADDR);
  wire hit_ctrl = (paddr == `SPIMSP_CTRL_ADDR);
  wire hit_stat = (paddr == `SPIMSP_STAT_ADDR);
  wire mapped = hit_data | hit_ctrl | hit_stat;
  wire data_wr = wr & hit_data;
  wire data_rd = rd & hit_data;
  wire stat_acc = acc & hit_stat;
  wire stat_rd = rd & hit_stat;
  wire ctrl_wr = wr & hit_ctrl;

  // mode fault: select pulled low while master
  wire fault = enable & master & ~sel_n;

  // edges of the serial clock in slave mode
  wire s_rise = sck_s_q[1] & ~sck_prev_q;
  wire s_fall = ~sck_s_q[1] & sck_prev_q;
  wire s_lead = clock_idle_level ? s_fall : s_rise;
  wire s_trail = clock_idle_level ? s_rise : s_fall;
  wire s_active = enable & ~master & ~sel_n;
  // synchronised data input of the current mode
  wire in_pin = master ? miso_s_q[1] : mosi_s_q[1];

  // master tick at each half period
  wire m_tick = busy_q & master & (div_q == 7'd1);
  // edge events common to both modes: leading, trailing
  wire lead = master ? (m_tick & ~phase_half_q) : (s_active & s_lead);
  wire trail = master ? (m_tick & phase_half_q) : (s_active & s_trail);
  // capture_edge_sel 0 samples on leading edge, capture_edge_sel 1 on trailing
  wire sample_ev = capture_edge_sel ? trail : lead;
  wire shift_ev = capture_edge_sel ? lead : trail;
  // byte end: last trailing edge
  wire last = trail & (bitcnt_q == `SPIMSP_BITS - 4'd1);
  // writes refused while done pending and status not yet accessed
  wire wr_block = done_q & ~done_seen_q;
  wire wr_ok = data_wr & ~busy_q & ~wr_block;
  // clearing sequence of the done flag
  wire done_clr = done_q & done_seen_q & (data_rd | data_wr);

  // ************************************************************
  // control and status registers
  // ************************************************************
  // hardware set wins over software clear on every flag
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q <= `SPIMSP_CTRL_RESET;
      done_q <= 1'b0;
      write_collision_flag_q <= 1'b0;
      ovr_q <= 1'b0;
      mode_fault_flag_q <= 1'b0;
      odis_q <= 1'b0;
      ssm_q <= 1'b0;
      ssi_q <= 1'b0;
      done_seen_q <= 1'b0;
      mode_fault_flag_seen_q <= 1'b0;
      write_collision_flag_seen_q <= 1'b0;
    end
    else
    begin
      // control write; enable and master held off while fault set and status not yet read
      if (ctrl_wr)
      begin
        ctrl_q <= pwdata[7:0];
        if (mode_fault_flag_q & ~mode_fault_flag_seen_q)
        begin
          ctrl_q[`SPIMSP_CTRL_PORT_EN] <= 1'b0;
          ctrl_q[`SPIMSP_CTRL_MASTER] <= 1'b0;
        end
      end
      if (fault)
      begin
        ctrl_q[`SPIMSP_CTRL_PORT_EN] <= 1'b0;
        ctrl_q[`SPIMSP_CTRL_MASTER] <= 1'b0;
      end
      // writable status bits
      if (wr & hit_stat)
      begin
        odis_q <= pwdata[`SPIMSP_STAT_ODIS];
        ssm_q <= pwdata[`SPIMSP_STAT_SSM];
        ssi_q <= pwdata[`SPIMSP_STAT_SSI];
      end
      // done flag
      if (stat_acc & done_q)
        done_seen_q <= 1'b1;
      else if (done_clr)
        done_seen_q <= 1'b0;
      if (last)
        done_q <= 1'b1;
      else if (done_clr)
        done_q <= 1'b0;
      // overrun: byte ready while done still set
      if (last & done_q)
        ovr_q <= 1'b1;
      else if (stat_rd)
        ovr_q <= 1'b0;
      // mode fault: status read while set, then control write
      if (stat_rd & mode_fault_flag_q)
        mode_fault_flag_seen_q <= 1'b1;
      else if (ctrl_wr)
        mode_fault_flag_seen_q <= 1'b0;
      if (fault)
        mode_fault_flag_q <= 1'b1;
      else if (ctrl_wr & mode_fault_flag_seen_q)
        mode_fault_flag_q <= 1'b0;
      // collision: status access then data access clears it
      if (stat_acc & write_collision_flag_q)
        write_collision_flag_seen_q <= 1'b1;
      else if (data_rd | data_wr)
        write_collision_flag_seen_q <= 1'b0;
      if (data_wr & busy_q)
        write_collision_flag_q <= 1'b1;
      else if (write_collision_flag_seen_q & (data_rd | data_wr))
        write_collision_flag_q <= 1'b0;
    end
  end

  // ************************************************************
  // shifter, bit counter and master clock
  // ************************************************************
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      shift_q <= 8'h00;
      rxbuf_q <= 8'h00;
      bitcnt_q <= 4'd0;
      busy_q <= 1'b0;
      sclk_q <= 1'b0;
      div_q <= 7'd0;
      phase_half_q <= 1'b0;
      latched_q <= 1'b0;
      in_bit_q <= 1'b0;
    end
    else
    begin
      if (done_clr)
        latched_q <= 1'b0;
      // a write loads the shifter directly; master starts clocking
      if (wr_ok)
      begin
        shift_q <= pwdata[7:0];
        bitcnt_q <= 4'd0;
        phase_half_q <= 1'b0;
        busy_q <= master & enable;
        div_q <= half_period(rate);
        // polarity may have changed while disabled; start from its idle level
        sclk_q <= clock_idle_level;
      end
      else if (~enable | (~master & sel_n))
      begin
        // disable or slave deselect aborts a partial byte
        busy_q <= 1'b0;
        bitcnt_q <= 4'd0;
        phase_half_q <= 1'b0;
        sclk_q <= clock_idle_level;
      end
      else
      begin
        if (~master & (s_lead | s_trail))
          busy_q <= 1'b1;
        // master divider, ignored in slave mode
        if (busy_q & master)
        begin
          if (div_q == 7'd1)
          begin
            div_q <= half_period(rate);
            sclk_q <= ~sclk_q;
            phase_half_q <= ~phase_half_q;
          end
          else
            div_q <= div_q - 7'd1;
        end
        if (sample_ev)
          in_bit_q <= in_pin;
        // msb first; with capture_edge_sel 1 the first leading edge must not shift,
        // the msb is already on the line for the first capture
        if (shift_ev & (~capture_edge_sel | bitcnt_q != 4'd0))
          shift_q <= {shift_q[6:0], in_bit_q};
        if (trail)
          bitcnt_q <= bitcnt_q + 4'd1;
        if (last)
        begin
          busy_q <= 1'b0;
          bitcnt_q <= 4'd0;
          sclk_q <= clock_idle_level;
          // buffer keeps the first byte since the flag was cleared
          if (~done_q | ~latched_q)
          begin
            rxbuf_q <= capture_edge_sel ? {shift_q[6:0], in_pin} : {shift_q[6:0], in_bit_q};
            latched_q <= 1'b1;
          end
          else
            rxbuf_q <= rxbuf_q;
        end
      end
    end
  end

  // ************************************************************
  // pins and bus answer
  // ************************************************************
  // all outputs registered; pins follow mode and enable, the data pins also follow disable
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      irq <= 1'b0;
      sck_out <= 1'b0;
      sck_oe <= 1'b0;
      mosi_out <= 1'b0;
      mosi_oe <= 1'b0;
      miso_out <= 1'b0;
      miso_oe <= 1'b0;
      pins_owned <= 1'b0;
    end
    else
    begin
      // one-wait answer: ready in the access cycle's next edge
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~mapped;
      prdata <= 32'h0000_0000;
      if (psel & ~pwrite)
      begin
        if (hit_data)
          prdata <= {24'h000000, rxbuf_q};
        else if (hit_ctrl)
          prdata <= {24'h000000, ctrl_q};
        else if (hit_stat)
          prdata <= {24'h000000, done_q, write_collision_flag_q, ovr_q, mode_fault_flag_q, 1'b0, odis_q, ssm_q, ssi_q};
      end
      // collision flag stays out of the request
      irq <= ctrl_q[`SPIMSP_CTRL_IRQ_EN] & (done_q | ovr_q | mode_fault_flag_q);
      pins_owned <= enable;
      sck_out <= busy_q & master ? sclk_q : clock_idle_level;
      sck_oe <= enable & master;
      mosi_out <= shift_q[7];
      miso_out <= shift_q[7];
      mosi_oe <= enable & master & ~odis_q;
      miso_oe <= enable & ~master & ~sel_n & ~odis_q;
    end
  end

endmodule

/* File: verif/spimsp_port_assertions.sv */
// concurrent checks on the serial port pins and apb answers
`timescale 1ns/1ps
`include "spimsp_regs.vh"
module spimsp_port_assertions
(
  // apb side
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // events and pins
  input wire irq,
  input wire sck_out,
  input wire sck_oe,
  input wire mosi_oe,
  input wire miso_oe,
  input wire pins_owned
);
  // ****
  // helpers
  // ****
  logic ien_q;
  wire st_rd = pready && !pwrite && !pslverr && paddr == `SPIMSP_STAT_ADDR;
  // shadow of interrupt enable; hardware never changes it
  always @(posedge pclk or negedge presetn)
    if (!presetn)
      ien_q <= 1'b0;
    else if (pready && pwrite && paddr == `SPIMSP_CTRL_ADDR)
      ien_q <= pwdata[7];
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_pins_free: assert property (!pins_owned [*2] |-> !sck_oe && !mosi_oe && !miso_oe)
    else $error("pins driven while port disabled");
  a_oe_release: assert property ($fell(pins_owned) |=> !sck_oe && !mosi_oe)
    else $error("outputs kept after disable");
  a_mosi_master: assert property (mosi_oe |-> sck_oe || $past(sck_oe))
    else $error("mosi driven outside master");
  a_miso_slave: assert property (sck_oe |-> !miso_oe)
    else $error("miso driven in master");
  a_irq_flags: assert property (st_rd |-> irq == (ien_q && (prdata[7] || prdata[5] || prdata[4])))
    else $error("irq disagrees with flags");
  a_write_collision_flag_quiet: assert property (st_rd && prdata[7:4] == 4'h4 |-> !irq)
    else $error("collision raised irq");
  a_irq_clear: assert property ($fell(irq) |-> $past(psel) || $past(psel, 2) || $past(psel, 3))
    else $error("irq dropped without access");
  a_sck_min_div: assert property (sck_oe && $past(sck_oe) && $changed(sck_out) |=> $stable(sck_out))
    else $error("sck faster than divide by four");
endmodule
bind spimsp_port spimsp_port_assertions spimsp_port_assertions_inst (.pclk(pclk),
  .presetn(presetn), .psel(psel), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .sck_out(sck_out),
  .sck_oe(sck_oe), .mosi_oe(mosi_oe), .miso_oe(miso_oe), .pins_owned(pins_owned));

/* File: verif/spimsp_peer.sv */
// far-side spi device: mode 0 slave, or mode 0 master at link rate
`timescale 1ns/1ps
module spimsp_peer
(
  // pins seen
  input wire sck,
  input wire mosi,
  input wire miso,
  input wire sel_n,
  // pins driven
  output logic p_sck,
  output logic p_mosi,
  output logic p_miso,
  output logic p_ss_n
);
  logic [7:0] stx = 8'h00;
  logic [7:0] srx = 8'h00;
  logic [7:0] mrx = 8'h00;
  initial
  begin
    p_sck = 1'b0;
    p_mosi = 1'b0;
    p_ss_n = 1'b1;
  end
  // slave role: sample on rise, shift on fall, msb first
  always @(posedge sck)
    if (!sel_n)
      srx <= {srx[6:0], mosi};
  always @(negedge sck)
    if (!sel_n)
      stx <= {stx[6:0], ~stx[7]};
  // deselected line shows the inverse so a stale bit never matches
  assign p_miso = sel_n ? ~stx[7] : stx[7];
  // master role; clock stands still outside frames
  task automatic xfer(input logic [7:0] b);
    // run half a port clock off its rising edge so no pin moves as it is sampled
    #10;
    p_ss_n = 1'b0;
    p_mosi = b[7];
    #160;
    for (int i = 0; i < 8; i++)
    begin
      #80 p_sck = 1'b1;
      mrx = {mrx[6:0], miso};
      #80 p_sck = 1'b0;
      b = {b[6:0], ~b[0]};
      p_mosi = b[7];
    end
    #160 p_ss_n = 1'b1;
    // hand back on a rising edge for the next bus call
    #10;
  endtask
endmodule

/* File: verif/testbench.sv */
// self-checking bench for the spi port
`timescale 1ns/1ps
`include "spimsp_regs.vh"
module testbench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, sel_n = 1, e, s;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [7:0] r;
  wire [31:0] prdata;
  wire pready, pslverr, irq, sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe, own;
  wire p_sck, p_mosi, p_miso, p_ss_n;
  // shared pin levels from the port's enables; the peer drives otherwise
  wire sck_w = sck_oe ? sck_out : p_sck;
  wire mosi_w = mosi_oe ? mosi_out : p_mosi;
  wire miso_w = miso_oe ? miso_out : p_miso;
  int fail_count = 0, checks = 0, cnt;
  logic [7:0] rate [6] = '{8'h20, 8'h00, 8'h01, 8'h22, 8'h02, 8'h03};
  always #10 pclk = ~pclk;
  spimsp_port spimsp_port_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .sck_in(sck_w), .sck_out(sck_out),
    .sck_oe(sck_oe), .mosi_in(mosi_w), .mosi_out(mosi_out), .mosi_oe(mosi_oe),
    .miso_in(miso_w), .miso_out(miso_out), .miso_oe(miso_oe), .ss_n_in(p_ss_n),
    .pins_owned(own));
  spimsp_peer spimsp_peer_inst (.sck(sck_w), .mosi(mosi_w), .miso(miso_w), .sel_n(sel_n),
    .p_sck(p_sck), .p_mosi(p_mosi), .p_miso(p_miso), .p_ss_n(p_ss_n));
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  // one apb transfer; held until pready is seen
  task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    // only the watchdog ends a wait that never gets its answer
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    r = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task rd(input logic [11:0] a, input logic [7:0] x);
    apb(1'b0, a, 8'h00);
    chk(r, x);
  endtask
  task wait_irq;
    for (int i = 0; i < 3000 && irq !== 1'b1; i++)
      @(posedge pclk);
    chk({7'h0, irq}, 8'h01);
  endtask
  task end_sim;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // watchdog, well past the expected run
  initial
  begin
    #400000;
    fail_count++;
    end_sim;
  end
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`SPIMSP_CTRL_ADDR, 8'h00);
    rd(`SPIMSP_STAT_ADDR, 8'h00);
    apb(1'b0, 12'h00c, 8'h00);
    chk({6'h0, e, own}, 8'h02);
    $display("reset test done");
    apb(1'b1, `SPIMSP_STAT_ADDR, 8'h03);
    apb(1'b1, `SPIMSP_CTRL_ADDR, 8'hd1);
    chk({6'h0, sck_oe, sck_out}, 8'h02);
    apb(1'b1, `SPIMSP_STAT_ADDR, 8'h07);
    chk({7'h0, mosi_oe}, 8'h00);
    apb(1'b1, `SPIMSP_STAT_ADDR, 8'h03);
    chk({7'h0, mosi_oe}, 8'h01);
    spimsp_peer_inst.stx = 8'ha5;
    sel_n <= 1'b0;
    apb(1'b1, `SPIMSP_DATA_ADDR, 8'h3c);
    apb(1'b1, `SPIMSP_DATA_ADDR, 8'h22);
    rd(`SPIMSP_STAT_ADDR, 8'h43);
    chk({7'h0, irq}, 8'h00);
    wait_irq;
    apb(1'b1, `SPIMSP_DATA_ADDR, 8'h55);
    repeat (40) @(posedge pclk);
    chk(spimsp_peer_inst.srx, 8'h3c);
    rd(`SPIMSP_STAT_ADDR, 8'h83);
    rd(`SPIMSP_DATA_ADDR, 8'ha5);
    rd(`SPIMSP_STAT_ADDR, 8'h03);
    $display("master test done");
    apb(1'b1, `SPIMSP_STAT_ADDR, 8'h02);
    repeat (4) @(posedge pclk);
    rd(`SPIMSP_CTRL_ADDR, 8'h81);
    rd(`SPIMSP_STAT_ADDR, 8'h12);
    chk({6'h0, irq, own}, 8'h02);
    apb(1'b1, `SPIMSP_STAT_ADDR, 8'h03);
    apb(1'b1, `SPIMSP_CTRL_ADDR, 8'h00);
    rd(`SPIMSP_STAT_ADDR, 8'h03);
    $display("fault test done");
    for (int i = 0; i < 6; i++)
    begin
      apb(1'b1, `SPIMSP_CTRL_ADDR, 8'h00);
      // odd steps run idle-high with second-edge capture
      apb(1'b1, `SPIMSP_CTRL_ADDR, rate[i] | 8'hd0 | {4'h0, i[0], i[0], 2'h0});
      chk({7'h0, sck_out}, {7'h0, i[0]});
      apb(1'b1, `SPIMSP_DATA_ADDR, 8'h96);
      s = sck_out;
      for (cnt = 0; cnt < 300 && sck_out === s; cnt++)
        @(posedge pclk);
      s = sck_out;
      for (cnt = 0; cnt < 300 && sck_out === s; cnt++)
        @(posedge pclk);
      chk(cnt[7:0], 8'h02 << i);
      wait_irq;
      chk(spimsp_peer_inst.srx, 8'h96);
      rd(`SPIMSP_STAT_ADDR, 8'h83);
      apb(1'b0, `SPIMSP_DATA_ADDR, 8'h00);
    end
    apb(1'b1, `SPIMSP_CTRL_ADDR, 8'h00);
    $display("rate test done");
    sel_n <= 1'b1;
    apb(1'b1, `SPIMSP_STAT_ADDR, 8'h00);
    apb(1'b1, `SPIMSP_CTRL_ADDR, 8'hc0);
    apb(1'b1, `SPIMSP_DATA_ADDR, 8'h96);
    spimsp_peer_inst.xfer(8'h5a);
    wait_irq;
    chk(spimsp_peer_inst.mrx, 8'h96);
    spimsp_peer_inst.xfer(8'h77);
    rd(`SPIMSP_STAT_ADDR, 8'ha0);
    rd(`SPIMSP_DATA_ADDR, 8'h5a);
    rd(`SPIMSP_STAT_ADDR, 8'h00);
    $display("slave test done");
    end_sim;
  end
endmodule
